// File: hw/fcpc_pkg.sv
// Package holding constants and types for the flash chip protection host controller.
package fcpc_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS       = 10;
    localparam int unsigned T_RESET_IDLE_NS     = 500;   // Reset pulse outside an algorithm.
    localparam int unsigned T_READY_NS          = 500;   // Device ready after reset.
    localparam int unsigned T_RESET_ALGO_US     = 10;    // Reset pulse during an algorithm.
    localparam int unsigned T_RESET_SETUP_US    = 4;     // High-voltage reset setup.
    localparam int unsigned T_VOLT_TRANS_US     = 4;     // High-voltage transition time.
    localparam int unsigned T_PROT_PULSE_US     = 10;    // Write pulse for protect.
    localparam int unsigned T_UNPROT_PULSE_MS   = 12;    // Write pulse for unprotect.
    localparam int unsigned T_STROBE_NS         = 100;   // Generic strobe width for commands and reads.

    localparam int unsigned CYC_RESET_IDLE   = (T_RESET_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CYC_READY        = (T_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CYC_RESET_ALGO   = (T_RESET_ALGO_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CYC_RESET_SETUP  = (T_RESET_SETUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CYC_VOLT_TRANS   = (T_VOLT_TRANS_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CYC_PROT_PULSE   = (T_PROT_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CYC_UNPROT_PULSE = (T_UNPROT_PULSE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CYC_STROBE       = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int unsigned CNT_W = 24;

    // ------------------------------------------------------------------
    // Bus layout
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 18;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ID_HV_ADDRESS_LINE     = 9;
    localparam int unsigned PROTECT_SELECT_LINE    = 6;
    localparam int unsigned ID_STATUS_SELECT_LINE  = 1;
    localparam int unsigned DATA_BIT_ZERO          = 0;

    // Command cycles: identifier read, unlock, reset.
    localparam logic [ADDR_W-1:0] CMD_ADDR_1 = 18'h00555;
    localparam logic [ADDR_W-1:0] CMD_ADDR_2 = 18'h002aa;
    localparam logic [DATA_W-1:0] CMD_DATA_1 = 8'haa;
    localparam logic [DATA_W-1:0] CMD_DATA_2 = 8'h55;
    localparam logic [DATA_W-1:0] CMD_ID_READ     = 8'h90;
    localparam logic [DATA_W-1:0] CMD_PROT_UNLOCK = 8'h77;   // Unlock for protection change.
    localparam logic [DATA_W-1:0] CMD_PROT_CYCLE  = 8'h00;   // Filler data for later cycles.
    localparam logic [DATA_W-1:0] CMD_READ_RESET  = 8'hf0;
    localparam logic [ADDR_W-1:0] STATUS_ADDR     = 18'h00002;
    localparam int unsigned       SW_CYCLES       = 7;       // Command cycles in the low-voltage method.
    localparam int unsigned       SEQ_W           = 4;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        FCPC_OP_HV_PROTECT,
        FCPC_OP_HV_UNPROTECT,
        FCPC_OP_HV_VERIFY,
        FCPC_OP_SW_PROTECT,
        FCPC_OP_SW_UNPROTECT,
        FCPC_OP_SYS_VERIFY,
        FCPC_OP_RESET_IDLE,
        FCPC_OP_RESET_ALGO
    } fcpc_op_t;

    // Pins driven toward the flash.
    typedef struct packed {
        logic              ce_n;
        logic              oe_n;
        logic              we_n;
        logic              reset_n;
        logic              hv_addr;    // Identifier high voltage on the address line.
        logic              hv_oe;      // Identifier high voltage on output enable.
        logic              hv_reset;   // Identifier high voltage on reset.
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_out;
        logic              dq_oe;
    } fcpc_pins_t;

    // Result returned to the user side.
    typedef struct packed {
        logic              protected_flag;
        logic [DATA_W-1:0] read_data;
    } fcpc_result_t;

endpackage

// File: hw/fcpc_timer.sv
// Down-counting delay timer used to pace the flash strobe sequence.
`timescale 1ns/1ps
module fcpc_timer
    import fcpc_pkg::*;
(
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] count,
    output logic                  done
);
    import fcpc_pkg::*;

    logic [CNT_W-1:0] cnt_q;

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    // A load restarts the count; done stays high once it runs out.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= count;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // Done is registered so the caller sees a clean level.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            done <= 1'b0;
        end else begin
            done <= !load && (cnt_q <= CNT_W'(1));
        end
    end

endmodule

// File: hw/fcpc_host.sv
// Host controller that protects, unprotects, verifies and resets a parallel flash over its pins.
// Functional notes
// - Protect: high voltage on address nine and OE, A6 low, CE low, WE pulse.
// - Verify: high voltage on address nine, CE OE low, WE high, status line high.
// - Unprotect: high voltage on OE and address nine, CE low, A6 high, WE pulse.
// - Without high voltage, protect-select on seventh cycle: low protects, high unprotects.
// - Host issues the protection unlock command as the third of the seven low-voltage command cycles.
// - Reset during an algorithm is held low at least 10 us.
// - Idle reset held at least 500 ns; device ready within 500 ns after.
// - Reset high voltage held at least 4 us before commands.
`timescale 1ns/1ps
module fcpc_host
    import fcpc_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              req_valid,
    input  fcpc_pkg::fcpc_op_t     req_op,
    output logic                   req_ready,
    output logic                   done_pulse,
    output fcpc_pkg::fcpc_result_t result,
    output fcpc_pkg::fcpc_pins_t   pins,
    input  wire logic [7:0]        dq_in
);
    import fcpc_pkg::*;
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_HV_SETUP,
        ST_WE_LOW,
        ST_WE_REC,
        ST_RD_SETUP,
        ST_RD_SAMPLE,
        ST_CMD_LOW,
        ST_CMD_HIGH,
        ST_RST_LOW,
        ST_RST_READY,
        ST_FINISH
    } fcpc_state_t;
    fcpc_state_t        state_q;
    fcpc_op_t           op_q;
    fcpc_pins_t         pins_q;
    logic [SEQ_W-1:0]   seq_q;
    logic [SEQ_W-1:0]   seq_len_q;
    logic               tmr_load;
    logic [CNT_W-1:0]   tmr_count;
    logic               tmr_done;
    logic [DATA_W-1:0]  dq_meta_q;
    logic [DATA_W-1:0]  dq_sync_q;
    logic [ADDR_W-1:0]  cmd_addr;
    logic [DATA_W-1:0]  cmd_data;
    // ------------------------------------------------------------------
    // Pacing timer
    // ------------------------------------------------------------------
    fcpc_timer u_timer (
        .sys_clk (sys_clk),
        .rst     (rst),
        .load    (tmr_load),
        .count   (tmr_count),
        .done    (tmr_done)
    );
    // Data from the flash is asynchronous and passes two flops first.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dq_meta_q <= '0;
            dq_sync_q <= '0;
        end else begin
            dq_meta_q <= dq_in;
            dq_sync_q <= dq_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Command cycle table
    // ------------------------------------------------------------------
    // Two unlock cycles precede every command so the device accepts it.
    always_comb begin
        cmd_addr = CMD_ADDR_1;
        cmd_data = CMD_DATA_1;
        if (seq_q == SEQ_W'(1)) begin
            cmd_addr = CMD_ADDR_2;
            cmd_data = CMD_DATA_2;
        end else if (seq_q == SEQ_W'(2)) begin
            cmd_addr = CMD_ADDR_1;
            cmd_data = (op_q == FCPC_OP_SYS_VERIFY) ? CMD_ID_READ : CMD_PROT_UNLOCK;
        end else if (seq_q > SEQ_W'(2)) begin
            cmd_addr = '0;
            cmd_data = CMD_PROT_CYCLE;
            if (seq_q == SEQ_W'(SW_CYCLES - 1)) begin
                cmd_addr[PROTECT_SELECT_LINE] = (op_q == FCPC_OP_SW_UNPROTECT);
            end
        end
    end
    // Timer reload per state entry; one-cycle load pulses.
    always_comb begin
        tmr_load  = 1'b0;
        tmr_count = CNT_W'(CYC_STROBE);
        case (state_q)
            ST_IDLE: begin
                if (req_valid) begin
                    tmr_load = 1'b1;
                    case (req_op)
                        FCPC_OP_RESET_IDLE: tmr_count = CNT_W'(CYC_RESET_IDLE);
                        FCPC_OP_RESET_ALGO: tmr_count = CNT_W'(CYC_RESET_ALGO);
                        FCPC_OP_SW_PROTECT, FCPC_OP_SW_UNPROTECT: tmr_count = CNT_W'(CYC_RESET_SETUP);
                        FCPC_OP_SYS_VERIFY: tmr_count = CNT_W'(CYC_STROBE);
                        default: tmr_count = CNT_W'(CYC_VOLT_TRANS);
                    endcase
                end
            end
            ST_HV_SETUP: begin
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    if (op_q == FCPC_OP_HV_PROTECT) begin
                        tmr_count = CNT_W'(CYC_PROT_PULSE);
                    end else if (op_q == FCPC_OP_HV_UNPROTECT) begin
                        tmr_count = CNT_W'(CYC_UNPROT_PULSE);
                    end
                end
            end
            ST_WE_LOW: begin
                if (tmr_done) begin
                    tmr_load  = 1'b1;
                    tmr_count = CNT_W'(CYC_VOLT_TRANS);
                end
            end
            ST_RST_LOW: begin
                if (tmr_done) begin
                    tmr_load  = 1'b1;
                    tmr_count = CNT_W'(CYC_READY);
                end
            end
            ST_WE_REC, ST_RD_SETUP, ST_CMD_LOW, ST_CMD_HIGH: begin
                tmr_load = tmr_done;
            end
            default: tmr_load = 1'b0;
        endcase
    end
    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Pins start deselected with reset released and no high voltage.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q   <= ST_IDLE;
            op_q      <= FCPC_OP_HV_VERIFY;
            seq_q     <= '0;
            seq_len_q <= '0;
            pins_q    <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b1, hv_addr: 1'b0,
                           hv_oe: 1'b0, hv_reset: 1'b0, addr: '0, dq_out: '0, dq_oe: 1'b0};
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (req_valid) begin
                        op_q  <= req_op;
                        seq_q <= '0;
                        case (req_op)
                            FCPC_OP_HV_PROTECT, FCPC_OP_HV_UNPROTECT: begin
                                pins_q.ce_n    <= 1'b0;
                                pins_q.hv_addr <= 1'b1;
                                pins_q.hv_oe   <= 1'b1;
                                pins_q.addr    <= '0;
                                pins_q.addr[PROTECT_SELECT_LINE] <= (req_op == FCPC_OP_HV_UNPROTECT);
                                state_q        <= ST_HV_SETUP;
                            end
                            FCPC_OP_HV_VERIFY: begin
                                pins_q.hv_addr <= 1'b1;
                                pins_q.addr    <= STATUS_ADDR;
                                state_q        <= ST_HV_SETUP;
                            end
                            FCPC_OP_RESET_IDLE, FCPC_OP_RESET_ALGO: begin
                                pins_q.reset_n <= 1'b0;
                                state_q        <= ST_RST_LOW;
                            end
                            FCPC_OP_SW_PROTECT, FCPC_OP_SW_UNPROTECT: begin
                                pins_q.hv_reset <= 1'b1;
                                seq_len_q       <= SEQ_W'(SW_CYCLES);
                                state_q         <= ST_RST_LOW;
                            end
                            default: begin
                                seq_len_q <= SEQ_W'(3);
                                state_q   <= ST_CMD_HIGH;
                            end
                        endcase
                    end
                end
                ST_HV_SETUP: begin
                    if (tmr_done) begin
                        if (op_q == FCPC_OP_HV_VERIFY) begin
                            state_q <= ST_RD_SETUP;
                        end else begin
                            pins_q.we_n <= 1'b0;
                            state_q     <= ST_WE_LOW;
                        end
                    end
                end
                ST_WE_LOW: begin
                    if (tmr_done) begin
                        pins_q.we_n <= 1'b1;
                        state_q     <= ST_WE_REC;
                    end
                end
                ST_WE_REC: begin
                    if (tmr_done) begin
                        pins_q.hv_oe <= 1'b0;
                        pins_q.ce_n  <= 1'b1;
                        pins_q.addr  <= STATUS_ADDR;
                        state_q      <= ST_HV_SETUP;
                        op_q         <= FCPC_OP_HV_VERIFY; // Verify right after programming.
                    end
                end
                ST_RD_SETUP: begin
                    pins_q.ce_n <= 1'b0;
                    pins_q.oe_n <= 1'b0;
                    if (tmr_done) begin
                        state_q <= ST_RD_SAMPLE;
                    end
                end
                ST_RD_SAMPLE: begin
                    pins_q.ce_n    <= 1'b1;
                    pins_q.oe_n    <= 1'b1;
                    pins_q.hv_addr <= 1'b0;
                    state_q        <= ST_FINISH;
                end
                ST_CMD_HIGH: begin
                    pins_q.ce_n   <= 1'b0;
                    pins_q.we_n   <= 1'b0;
                    pins_q.dq_oe  <= 1'b1;
                    pins_q.addr   <= cmd_addr;
                    pins_q.dq_out <= cmd_data;
                    state_q       <= ST_CMD_LOW;
                end
                ST_CMD_LOW: begin
                    if (tmr_done) begin
                        pins_q.we_n  <= 1'b1;
                        pins_q.ce_n  <= 1'b1;
                        pins_q.dq_oe <= 1'b0;
                        seq_q        <= seq_q + 1'b1;
                        if (seq_q + 1'b1 == seq_len_q) begin
                            pins_q.addr <= STATUS_ADDR;
                            state_q     <= (op_q == FCPC_OP_SYS_VERIFY) ? ST_RD_SETUP : ST_FINISH;
                        end else begin
                            state_q <= ST_CMD_HIGH;
                        end
                    end
                end
                ST_RST_LOW: begin
                    if (tmr_done) begin
                        pins_q.reset_n <= 1'b1;
                        state_q        <= (seq_len_q != '0) ? ST_CMD_HIGH : ST_RST_READY;
                    end
                end
                ST_RST_READY: begin
                    if (tmr_done) begin
                        state_q <= ST_FINISH;
                    end
                end
                ST_FINISH: begin
                    pins_q.hv_reset <= 1'b0;
                    seq_len_q       <= '0;
                    state_q         <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
    // ------------------------------------------------------------------
    // Result capture
    // ------------------------------------------------------------------
    // Status bit zero flags protection; all-zero means unprotected.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            result <= '0;
        end else if (state_q == ST_RD_SAMPLE) begin
            result.read_data      <= dq_sync_q;
            result.protected_flag <= dq_sync_q[DATA_BIT_ZERO];
        end
    end
    // Handshake outputs come from flops.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            req_ready  <= 1'b0;
            done_pulse <= 1'b0;
        end else begin
            req_ready  <= (state_q == ST_IDLE) && !req_valid;
            done_pulse <= (state_q == ST_FINISH);
        end
    end
    assign pins = pins_q;
endmodule

// File: dv/fcpc_host_checker.sv
// Concurrent checks on the flash protection host controller ports.
`timescale 1ns/1ps
module fcpc_host_checker
    import fcpc_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              rst,
    input wire logic              req_valid,
    input fcpc_pkg::fcpc_op_t     req_op,
    input wire logic              req_ready,
    input wire logic              done_pulse,
    input fcpc_pkg::fcpc_result_t result,
    input fcpc_pkg::fcpc_pins_t   pins,
    input wire logic [7:0]        dq_in
);
    import fcpc_pkg::*;
    // ------------------------------------------------------------
    // Helper counters and sequences
    // ------------------------------------------------------------
    logic [CNT_W-1:0] rlow_q;
    logic [CNT_W-1:0] hvr_q;
    logic             algo_q;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Count how long reset and the high-voltage reset qualifier stand, and note a long reset request.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rlow_q <= '0;
            hvr_q  <= '0;
            algo_q <= 1'b0;
        end else begin
            rlow_q <= pins.reset_n ? '0 : rlow_q + 1'b1;
            hvr_q  <= pins.hv_reset ? hvr_q + 1'b1 : '0;
            if (req_valid && req_ready) algo_q <= (req_op == FCPC_OP_RESET_ALGO);
        end
    end
    sequence s_take;
        req_valid && req_ready;
    endsequence
    sequence s_hv_write;
        !pins.we_n && pins.hv_addr && pins.hv_oe;
    endsequence
    chk_take_busy: assert property (s_take |=> !req_ready [*2]) else $error("ready stayed high after take");
    chk_done_single: assert property ($rose(done_pulse) |=> !done_pulse) else $error("done longer than one cycle");
    chk_hv_chip_en: assert property (s_hv_write |-> !pins.ce_n) else $error("protect pulse without chip enable");
    chk_verify_strobes: assert property (pins.hv_addr && !pins.hv_oe && !pins.oe_n |->
        pins.we_n && pins.addr[ID_STATUS_SELECT_LINE]) else $error("verify read with bad strobes");
    chk_write_inhibit: assert property (!pins.we_n && !pins.hv_oe |-> pins.oe_n && !pins.ce_n)
        else $error("command write with bad strobes");
    chk_bus_contend: assert property (pins.dq_oe |-> pins.oe_n) else $error("data driven while reading");
    chk_idle_quiet: assert property (req_ready |-> pins.ce_n && pins.we_n && pins.reset_n &&
        !pins.hv_addr && !pins.hv_oe && !pins.hv_reset) else $error("pins active while idle");
    chk_reset_width: assert property ($rose(pins.reset_n) |-> rlow_q >= CYC_RESET_IDLE)
        else $error("reset pulse too short");
    chk_algo_reset: assert property ($rose(pins.reset_n) && algo_q |-> rlow_q >= CYC_RESET_ALGO)
        else $error("algorithm reset pulse too short");
    chk_hv_reset_setup: assert property ($fell(pins.hv_reset) |-> hvr_q >= CYC_RESET_SETUP)
        else $error("high voltage reset too short");
    chk_early_command: assert property (!pins.we_n && pins.hv_reset |-> hvr_q >= CYC_RESET_SETUP)
        else $error("command before high voltage reset setup");
    cov_algo_reset: cover property ($rose(pins.reset_n) && rlow_q >= CYC_RESET_ALGO);
endmodule
bind fcpc_host fcpc_host_checker u_chk (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req_op(req_op),
    .req_ready(req_ready), .done_pulse(done_pulse), .result(result), .pins(pins), .dq_in(dq_in));

// File: dv/fcpc_flash_model.sv
// Behavioural model of the flash protection logic seen on the pins.
`timescale 1ns/1ps
module fcpc_flash_model
    import fcpc_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'h3c   // Arbitrary value.
) (
    input wire logic            sys_clk,
    input fcpc_pkg::fcpc_pins_t pins,
    output logic [7:0]          dq_in
);
    import fcpc_pkg::*;
    // ------------------------------------------------------------
    // Protection state and command decoding
    // ------------------------------------------------------------
    fcpc_pins_t p_q;
    logic       prot_q = 1'b0;
    logic       id_q   = 1'b0;
    logic       unl_q  = 1'b0;
    logic [2:0] cnt_q  = 3'h0;
    logic [7:0] dq_q   = 8'h00;
    logic       rise;
    logic       rd;
    assign rise  = !p_q.we_n && pins.we_n;
    assign rd    = !pins.ce_n && !pins.oe_n && pins.we_n;
    assign dq_in = dq_q;
    // Writes act only on a rising write strobe, so a glitch-free pulse is assumed.
    always_ff @(posedge sys_clk) begin
        p_q <= pins;
        if (!pins.reset_n) begin
            id_q  <= 1'b0;
            cnt_q <= 3'h0;
            unl_q <= 1'b0;
        end else if (rise && p_q.hv_addr && p_q.hv_oe && !p_q.ce_n) begin
            prot_q <= !p_q.addr[PROTECT_SELECT_LINE];
        end else if (rise && !p_q.ce_n && p_q.oe_n) begin
            cnt_q <= cnt_q + 3'h1;
            if ((cnt_q == 3'h0 && p_q.dq_out != CMD_DATA_1) || (cnt_q == 3'h1 && p_q.dq_out != CMD_DATA_2))
                cnt_q <= 3'h0;
            if (cnt_q == 3'h2 && p_q.dq_out == CMD_ID_READ) begin
                id_q  <= 1'b1;
                cnt_q <= 3'h0;
            end
            if (cnt_q == 3'h2 && p_q.dq_out == CMD_READ_RESET) begin
                id_q  <= 1'b0;
                cnt_q <= 3'h0;
            end
            if (cnt_q == 3'h2) unl_q <= (p_q.dq_out == CMD_PROT_UNLOCK);
            if (cnt_q == 3'h6) begin
                cnt_q <= 3'h0;
                if (unl_q) prot_q <= !p_q.addr[PROTECT_SELECT_LINE];
            end
        end
    end
    // Read data; a released bus shows a pattern that changes every cycle.
    always_ff @(posedge sys_clk) begin
        if (rd && (pins.hv_addr || id_q))
            dq_q <= pins.addr[ID_STATUS_SELECT_LINE] ? {7'h00, prot_q} : MAKER_CODE;
        else if (rd)
            dq_q <= 8'hff;
        else
            dq_q <= ~dq_q;
    end
endmodule

// File: dv/tb.sv
// Self-checking testbench for the flash protection host controller.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
    import fcpc_pkg::*;
    // ------------------------------------------------------------
    // Clock, reset and design
    // ------------------------------------------------------------
    logic         sys_clk = 1'b0;
    logic         rst = 1'b1;
    logic         req_valid = 1'b0;
    fcpc_op_t     req_op = FCPC_OP_HV_VERIFY;
    logic         req_ready;
    logic         done_pulse;
    fcpc_result_t result;
    fcpc_pins_t   pins;
    logic [7:0]   dq_in;
    logic [9:0]   exp_q[$];
    logic [9:0]   note;
    logic         prot_e = 1'b0;
    int           bad_count = 0;
    int           num_checks = 0;
    int           cyc = 0;
    int           seed = 2;
    int           r;
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    fcpc_host u_fcpc_host (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req_op(req_op),
        .req_ready(req_ready), .done_pulse(done_pulse), .result(result), .pins(pins), .dq_in(dq_in));
    fcpc_flash_model u_fcpc_flash_model (.sys_clk(sys_clk), .pins(pins), .dq_in(dq_in));
    task automatic conclude;
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Hold valid a few cycles past the take; a busy block must ignore the extra cycles.
    task automatic run_op(input fcpc_op_t op);
        logic chk;
        chk = (op == FCPC_OP_HV_PROTECT || op == FCPC_OP_HV_VERIFY || op == FCPC_OP_SYS_VERIFY);
        if (op == FCPC_OP_HV_PROTECT || op == FCPC_OP_SW_PROTECT) prot_e = 1'b1;
        if (op == FCPC_OP_SW_UNPROTECT || op == FCPC_OP_HV_UNPROTECT) prot_e = 1'b0;
        @(posedge sys_clk);
        while (req_ready !== 1'b1) @(posedge sys_clk);
        exp_q.push_back({chk, prot_e, 7'h00, prot_e});
        req_valid <= 1'b1;
        req_op    <= op;
        repeat (4) @(posedge sys_clk);
        req_valid <= 1'b0;
        @(posedge sys_clk iff done_pulse === 1'b1);
        repeat (2) @(posedge sys_clk);
    endtask
    // Watcher: each done pulse retires the oldest note.
    always @(posedge sys_clk) begin
        if (done_pulse === 1'b1) begin
            `CHK(exp_q.size() > 0, 1'b1)
            if (exp_q.size() > 0) begin
                note = exp_q.pop_front();
                if (note[9]) begin
                    `CHK(result.protected_flag, note[8])
                    `CHK(result.read_data, note[7:0])
                end
            end
        end
    end
    // Long operations end in a cut-off report rather than a hang.
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 100000) begin
            bad_count++;
            conclude();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge sys_clk);
        `CHK(pins.we_n, 1'b1)
        `CHK(pins.hv_addr, 1'b0)
        rst <= 1'b0;
        run_op(FCPC_OP_HV_PROTECT);
        run_op(FCPC_OP_SYS_VERIFY);
        run_op(FCPC_OP_RESET_IDLE);
        run_op(FCPC_OP_HV_VERIFY);
        run_op(FCPC_OP_SW_UNPROTECT);
        run_op(FCPC_OP_SYS_VERIFY);
        run_op(FCPC_OP_HV_VERIFY);
        run_op(FCPC_OP_SW_PROTECT);
        run_op(FCPC_OP_RESET_ALGO);
        run_op(FCPC_OP_HV_VERIFY);
        // The 12 ms unprotect pulse does not fit the run, so it stays out of the random mix.
        repeat (6) begin
            r = $unsigned($random(seed)) % 8;
            if (r == 1) r = 2;
            run_op(fcpc_op_t'(r));
        end
        `CHK(exp_q.size() == 0, 1'b1)
        conclude();
    end
endmodule
